// File: rtl/dswf_top.sv
// Purpose: Wake-source flags of the retention sleep state, AXI4-Lite mapped
// Assumes: clk at 25 MHz; reset_n is the true power-on reset
// Notes:   Pins pass four flops; watchdog, alarm, fault come from clk logic
// Function
// - External irq line zero in sleep sets flag
// - Retention fault in sleep sets bit 7
// - Watchdog expiry in sleep sets bit 4
// - Calendar alarm in sleep sets bit 3
// - Reset pin in sleep sets bit 2
// - Only power-on flag may set outside sleep
// - Power-on event sets bit 0 anywhere
// - Brownout in sleep recorded only, never wakes
`default_nettype none
`include "dswf_defs.svh"
module dswf_top
   import dswf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axil_araddr,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   // Device pins
   input wire logic external_irq_line_zero,
   input wire logic master_reset_pin_n,
   input wire logic por_detect,
   input wire logic brownout_detect,
   // Same-clock event sources
   input wire logic watchdog_expire,
   input wire logic calendar_alarm,
   input wire logic retention_fault,
   // Status out
   output logic retention_sleep_active,
   output logic irq
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   dswf_state_t state_ff, nxt_state;
   dswf_pins_t pins_raw, pins_s;
   dswf_wr_t wr_req;
   logic wr_fire, rd_fire, wr_err, rd_err;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic [15:0] wake_ff, nxt_wake, wake_set;
   logic [2:0] ctrl_ff, nxt_ctrl;
   logic [1:0] istat_ff, nxt_istat, imask_ff;
   logic in_sleep, wake_ev, sleep_req, bor_ev;
   logic wr_wake, wr_ctrl, wr_imask, rd_istat;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Address decode shared by reads and writes
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `DSWF_OFF_WAKE) || (a == `DSWF_OFF_CTRL) ||
               (a == `DSWF_OFF_ISTAT) || (a == `DSWF_OFF_IMASK);
   endfunction

   // Write-zero-to-clear over the low two byte lanes
   function automatic logic [15:0] w0c(input logic [15:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = old[7:0] & d[7:0];
      end
      if (s[1]) begin
         r[15:8] = old[15:8] & d[15:8];
      end
      w0c = r;
   endfunction

   // ------------------------------------------------------------
   // Bus slave and pin synchronisers
   // ------------------------------------------------------------
   dswf_axil u_dswf_axil (
      .clk(clk),
      .reset_n(reset_n),
      .awaddr(s_axil_awaddr),
      .awvalid(s_axil_awvalid),
      .awready(s_axil_awready),
      .wdata(s_axil_wdata),
      .wstrb(s_axil_wstrb),
      .wvalid(s_axil_wvalid),
      .wready(s_axil_wready),
      .bresp(s_axil_bresp),
      .bvalid(s_axil_bvalid),
      .bready(s_axil_bready),
      .araddr(s_axil_araddr),
      .arvalid(s_axil_arvalid),
      .arready(s_axil_arready),
      .rdata(s_axil_rdata),
      .rresp(s_axil_rresp),
      .rvalid(s_axil_rvalid),
      .rready(s_axil_rready),
      .wr_fire(wr_fire),
      .wr_req(wr_req),
      .wr_err(wr_err),
      .rd_fire(rd_fire),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // Reset pin folded to active high so the idle-low sync reset fits
   assign pins_raw.brownout = brownout_detect;
   assign pins_raw.por = por_detect;
   assign pins_raw.master_reset_pin = !master_reset_pin_n;
   assign pins_raw.ext_irq = external_irq_line_zero;

   dswf_sync3 u_dswf_sync3 (
      .clk(clk),
      .reset_n(reset_n),
      .pins_in(pins_raw),
      .pins_out(pins_s)
   );

   // ------------------------------------------------------------
   // Write and read decode
   // ------------------------------------------------------------
   assign wr_err = !mapped(wr_req.addr);
   assign rd_err = !mapped(rd_addr);
   assign wr_wake = wr_fire && (wr_req.addr == `DSWF_OFF_WAKE);
   assign wr_ctrl = wr_fire && (wr_req.addr == `DSWF_OFF_CTRL);
   assign wr_imask = wr_fire && (wr_req.addr == `DSWF_OFF_IMASK);
   assign rd_istat = rd_fire && (rd_addr == `DSWF_OFF_ISTAT);
   assign sleep_req = wr_ctrl && wr_req.strb[0] && wr_req.data[`DSWF_CTRL_SLEEP];

   // ------------------------------------------------------------
   // Sleep state
   // ------------------------------------------------------------
   assign in_sleep = (state_ff == ST_SLEEP);
   assign retention_sleep_active = in_sleep;
   // Brownout is left out of the wake term on purpose
   assign wake_ev = in_sleep && (|wake_set);
   assign bor_ev = in_sleep && pins_s.brownout;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (sleep_req) begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_ev) begin
               nxt_state = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // Wake source flags
   // ------------------------------------------------------------
   always_comb begin
      wake_set = `DSWF_WAKE_RST;
      wake_set[`DSWF_BIT_EXTIRQ] = in_sleep && pins_s.ext_irq;
      wake_set[`DSWF_BIT_FAULT] = in_sleep && retention_fault;
      wake_set[`DSWF_BIT_WDT] = in_sleep && watchdog_expire;
      wake_set[`DSWF_BIT_RTC] = in_sleep && calendar_alarm;
      wake_set[`DSWF_BIT_MASTER_RESET_PIN] = in_sleep && pins_s.master_reset_pin;
      wake_set[`DSWF_BIT_POR] = pins_s.por;
   end

   always_comb begin
      nxt_wake = wake_ff;
      if (wr_wake) begin
         nxt_wake = w0c(wake_ff, wr_req.data, wr_req.strb);
      end
      // Set beats a clear in the same cycle
      nxt_wake = (nxt_wake | wake_set) & `DSWF_WAKE_IMPL;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_ff <= `DSWF_WAKE_RST;
      end else begin
         wake_ff <= nxt_wake;
      end
   end

   // ------------------------------------------------------------
   // Control: sleep state, brownout record, sleep status
   // ------------------------------------------------------------
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl && wr_req.strb[0]) begin
         nxt_ctrl[`DSWF_CTRL_BOR] = ctrl_ff[`DSWF_CTRL_BOR] && wr_req.data[`DSWF_CTRL_BOR];
         nxt_ctrl[`DSWF_CTRL_RSTAT] = ctrl_ff[`DSWF_CTRL_RSTAT] && wr_req.data[`DSWF_CTRL_RSTAT];
      end
      if (bor_ev) begin
         nxt_ctrl[`DSWF_CTRL_BOR] = 1'b1;
      end
      if (state_ff == ST_RUN && sleep_req) begin
         nxt_ctrl[`DSWF_CTRL_RSTAT] = 1'b1;
      end
      nxt_ctrl[`DSWF_CTRL_SLEEP] = (nxt_state == ST_SLEEP);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= `DSWF_CTRL_RST;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // ------------------------------------------------------------
   // Interrupt status (clear on read) and mask
   // ------------------------------------------------------------
   always_comb begin
      nxt_istat = rd_istat ? `DSWF_IRQ_RST : istat_ff;
      if (wake_ev) begin
         nxt_istat[`DSWF_IRQ_WAKE] = 1'b1;
      end
      if (bor_ev) begin
         nxt_istat[`DSWF_IRQ_BOR] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         istat_ff <= `DSWF_IRQ_RST;
      end else begin
         istat_ff <= nxt_istat;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         imask_ff <= `DSWF_IRQ_RST;
      end else if (wr_imask && wr_req.strb[0]) begin
         imask_ff <= wr_req.data[1:0];
      end
   end

   assign irq = |(istat_ff & imask_ff);

   // ------------------------------------------------------------
   // Read data; unused bits read as zero
   // ------------------------------------------------------------
   always_comb begin
      rd_data = `DSWF_ZERO32;
      unique case (rd_addr)
         `DSWF_OFF_WAKE: rd_data[15:0] = wake_ff;
         `DSWF_OFF_CTRL: rd_data[2:0] = ctrl_ff;
         `DSWF_OFF_ISTAT: rd_data[1:0] = istat_ff;
         `DSWF_OFF_IMASK: rd_data[1:0] = imask_ff;
         default: rd_data = `DSWF_ZERO32;
      endcase
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence seq_asleep_and(logic ev);
      in_sleep && ev;
   endsequence

   sequence seq_no_clear_wake;
      !wr_wake;
   endsequence

   AST_EXT_IRQ_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
      seq_asleep_and(pins_s.ext_irq) |=> wake_ff[`DSWF_BIT_EXTIRQ])
      else $error("ext irq in sleep did not set flag");

   AST_FAULT_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
      seq_asleep_and(retention_fault) |=> wake_ff[`DSWF_BIT_FAULT] && !in_sleep)
      else $error("fault in sleep did not set flag and wake");

   AST_WDT_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
      seq_asleep_and(watchdog_expire) |=> wake_ff[`DSWF_BIT_WDT])
      else $error("watchdog expiry in sleep did not set flag");

   AST_RTC_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
      seq_asleep_and(calendar_alarm) |=> wake_ff[`DSWF_BIT_RTC])
      else $error("alarm in sleep did not set flag");

   AST_MASTER_RESET_PIN_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
      seq_asleep_and(pins_s.master_reset_pin) ##1 seq_no_clear_wake |=> wake_ff[`DSWF_BIT_MASTER_RESET_PIN])
      else $error("reset pin in sleep did not set flag");

   AST_SLEEP_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
      !in_sleep |=> (wake_ff & `DSWF_WAKE_SLEEP_ONLY & ~$past(wake_ff)) == `DSWF_WAKE_RST)
      else $error("sleep-only flag set outside sleep");

   AST_POR_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
      pins_s.por |=> wake_ff[`DSWF_BIT_POR])
      else $error("power-on event did not set flag");

   AST_BOR_NO_WAKE: assert property (@(posedge clk) disable iff (!reset_n)
      bor_ev && !(|wake_set) |=> in_sleep && ctrl_ff[`DSWF_CTRL_BOR])
      else $error("brownout woke device or was not recorded");

   AST_W0C: assert property (@(posedge clk) disable iff (!reset_n)
      wr_wake && wr_req.strb[1:0] == 2'h3 && wr_req.data[15:0] == 16'h0000 && !(|wake_set)
      |=> wake_ff == `DSWF_WAKE_RST && s_axil_bvalid)
      else $error("write of zero did not clear flags");

   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
      wake_ev && imask_ff[`DSWF_IRQ_WAKE] && !wr_imask |=> irq)
      else $error("unmasked wake did not raise irq");
endmodule
`default_nettype wire

// File: rtl/dswf_defs.svh
// Purpose: Offsets, field positions and reset values of the wake-flag block
// Assumes: 32-bit AXI4-Lite data, 8-bit byte address
// Notes:   Definitions only
`ifndef DSWF_DEFS_SVH
`define DSWF_DEFS_SVH

// ------------------------------------------------------------
// Address map
// ------------------------------------------------------------
`define DSWF_AW 8
`define DSWF_OFF_WAKE 8'h00
`define DSWF_OFF_CTRL 8'h04
`define DSWF_OFF_ISTAT 8'h08
`define DSWF_OFF_IMASK 8'h0C

// ------------------------------------------------------------
// Wake source register fields
// ------------------------------------------------------------
`define DSWF_BIT_EXTIRQ 8
`define DSWF_BIT_FAULT 7
`define DSWF_BIT_WDT 4
`define DSWF_BIT_RTC 3
`define DSWF_BIT_MASTER_RESET_PIN 2
`define DSWF_BIT_POR 0
`define DSWF_WAKE_IMPL 16'h019D
`define DSWF_WAKE_SLEEP_ONLY 16'h019C
`define DSWF_WAKE_RST 16'h0000

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define DSWF_CTRL_SLEEP 0
`define DSWF_CTRL_BOR 1
`define DSWF_CTRL_RSTAT 2
`define DSWF_CTRL_RST 3'h0

// ------------------------------------------------------------
// Interrupt status and mask fields
// ------------------------------------------------------------
`define DSWF_IRQ_WAKE 0
`define DSWF_IRQ_BOR 1
`define DSWF_IRQ_RST 2'h0

// ------------------------------------------------------------
// Bus answers
// ------------------------------------------------------------
`define DSWF_RESP_OKAY 2'h0
`define DSWF_RESP_SLVERR 2'h2
`define DSWF_ZERO32 32'h0000_0000

`endif

// File: rtl/dswf_pkg.sv
// Purpose: Types shared by the wake-flag block
// Assumes: Nothing beyond the defs header
// Notes:   Types only; numbers live in dswf_defs.svh
`default_nettype none
package dswf_pkg;

   typedef enum logic {ST_RUN, ST_SLEEP} dswf_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } dswf_wr_t;

   typedef struct packed {
      logic brownout;
      logic por;
      logic master_reset_pin;
      logic ext_irq;
   } dswf_pins_t;

endpackage
`default_nettype wire

// File: rtl/dswf_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter, one per bit
// Assumes: Inputs are idle-low after the pin polarity is folded in
// Notes:   Stage one feeds stage two only
`default_nettype none
module dswf_sync3
   import dswf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Pins in, filtered levels out
   input wire dswf_pins_t pins_in,
   output dswf_pins_t pins_out
);
   localparam int W = $bits(dswf_pins_t);
   logic [W-1:0] s1_ff, s2_ff, s3_ff, filt_ff;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               s1_ff[i] <= 1'b0;
               s2_ff[i] <= 1'b0;
               s3_ff[i] <= 1'b0;
               filt_ff[i] <= 1'b0;
            end else begin
               s1_ff[i] <= pins_in[i];
               s2_ff[i] <= s1_ff[i];
               s3_ff[i] <= s2_ff[i];
               // A change counts only once two stages agree
               if (s2_ff[i] == s3_ff[i]) begin
                  filt_ff[i] <= s3_ff[i];
               end
            end
         end
      end
   endgenerate

   assign pins_out = filt_ff;
endmodule
`default_nettype wire

// File: rtl/dswf_axil.sv
// Purpose: AXI4-Lite slave front end for the wake-flag registers
// Assumes: One write and one read outstanding at most
// Notes:   Write strobe one edge after both AW and W are held
`default_nettype none
`include "dswf_defs.svh"
module dswf_axil
   import dswf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Write address and data
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address and data
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side
   output logic wr_fire,
   output dswf_wr_t wr_req,
   input wire logic wr_err,
   output logic rd_fire,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   dswf_wr_t req_ff;

   assign awready = !aw_hold_ff && !bvalid_ff;
   assign wready = !w_hold_ff && !bvalid_ff;
   assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_req = req_ff;
   assign arready = !rvalid_ff;
   assign rd_fire = arvalid && arready;
   assign rd_addr = araddr;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rresp = rresp_ff;
   assign rdata = rdata_ff;

   // ------------------------------------------------------------
   // Write channels, taken in either order
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         req_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `DSWF_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_hold_ff <= 1'b1;
            req_ff.addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_ff <= 1'b1;
            req_ff.data <= wdata;
            req_ff.strb <= wstrb;
         end
         if (wr_fire) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_err ? `DSWF_RESP_SLVERR : `DSWF_RESP_OKAY;
         end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= `DSWF_ZERO32;
         rresp_ff <= `DSWF_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_data;
         rresp_ff <= rd_err ? `DSWF_RESP_SLVERR : `DSWF_RESP_OKAY;
      end else if (rvalid_ff && rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   AST_BVALID_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("bvalid dropped before bready");
endmodule
`default_nettype wire

// File: verif/dswf_top_tb.sv
// Purpose: Self-checking bench for the wake-flag register block
// Assumes: Offsets and bit positions come from dswf_defs.svh
// Notes:   Pins pass a synchroniser, so settle waits cover that latency
`default_nettype none
`include "dswf_defs.svh"
module dswf_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic reset_n;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, wv;
   logic [3:0] wstrb;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, sleep_o, irq;
   logic [1:0] bresp, rresp, r;
   logic eirq, mrst_n, por, bor, wdt, cal, flt;
   logic [15:0] cur;
   int errors, n_checks;

   dswf_top u_dswf_top (.clk(clk), .reset_n(reset_n),
      .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
      .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
      .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
      .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
      .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
      .external_irq_line_zero(eirq), .master_reset_pin_n(mrst_n), .por_detect(por),
      .brownout_detect(bor), .watchdog_expire(wdt), .calendar_alarm(cal), .retention_fault(flt),
      .retention_sleep_active(sleep_o), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic finish_test();
      $display("Checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Handshakes are judged at the negedge so the edge sees the same values
   task automatic axw(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
      logic ha, hw, hb;
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         resp = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end while (!hb);
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
      logic ha, hr;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         ha = arvalid && arready;
         hr = rvalid;
         dat = rdata;
         resp = rresp;
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
      end while (!hr);
      rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] got;
      logic [1:0] resp;
      axr(a, got, resp);
      chk(got, exp, what);
      chk(resp, `DSWF_RESP_OKAY, "mapped read resp");
   endtask

   task automatic pin_chk(input bit sel_irq, input logic exp, input string what);
      @(negedge clk);
      chk(sel_irq ? irq : sleep_o, {31'h0, exp}, what);
      @(posedge clk);
   endtask

   task automatic set_src(input int i, input logic v);
      case (i)
         0: eirq <= v;
         1: flt <= v;
         2: wdt <= v;
         3: cal <= v;
         4: mrst_n <= !v;
         default: por <= v;
      endcase
   endtask

   function automatic logic [31:0] src_mask(input int i);
      case (i)
         0: return 32'h1 << `DSWF_BIT_EXTIRQ;
         1: return 32'h1 << `DSWF_BIT_FAULT;
         2: return 32'h1 << `DSWF_BIT_WDT;
         3: return 32'h1 << `DSWF_BIT_RTC;
         4: return 32'h1 << `DSWF_BIT_MASTER_RESET_PIN;
         default: return 32'h1 << `DSWF_BIT_POR;
      endcase
   endfunction

   // Bounded: a block that never wakes is caught by the next compare
   task automatic wait_wake();
      int n;
      n = 0;
      while (sleep_o !== 1'b0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      {eirq, por, bor, wdt, cal, flt} = '0;
      wstrb = 4'hF;
      mrst_n = 1'b1;
      reset_n = 1'b0;
      errors = 0;
      n_checks = 0;
      void'($urandom(25096));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd_chk(`DSWF_OFF_WAKE, 32'h0, "wake after reset");
      axr(8'h40, wv, r);
      chk(r, `DSWF_RESP_SLVERR, "unmapped read resp");
      chk(wv, 32'h0, "unmapped read data");
      axw(8'h40, 32'hFFFF_FFFF, r);
      chk(r, `DSWF_RESP_SLVERR, "unmapped write resp");
      for (int i = 0; i < 5; i++) set_src(i, 1'b1);
      repeat (12) @(posedge clk);
      pin_chk(0, 1'b0, "no sleep from sources");
      for (int i = 0; i < 5; i++) set_src(i, 1'b0);
      set_src(5, 1'b1);
      repeat (12) @(posedge clk);
      rd_chk(`DSWF_OFF_WAKE, src_mask(5), "power-on flag in run");
      set_src(5, 1'b0);
      // The synced pin stays high for a few edges and a set beats the clear
      repeat (12) @(posedge clk);
      axw(`DSWF_OFF_WAKE, 32'h0, r);
      rd_chk(`DSWF_OFF_WAKE, 32'h0, "clear by zero");
      for (int i = 0; i < 5; i++) begin
         axw(`DSWF_OFF_IMASK, 32'(i != 0), r);
         axw(`DSWF_OFF_CTRL, 32'h1, r);
         pin_chk(0, 1'b1, "sleep entered");
         set_src(i, 1'b1);
         wait_wake();
         set_src(i, 1'b0);
         pin_chk(0, 1'b0, "woke");
         pin_chk(1, i != 0, "irq follows mask");
         rd_chk(`DSWF_OFF_WAKE, src_mask(i), "one source flag");
         rd_chk(`DSWF_OFF_CTRL, 32'h1 << `DSWF_CTRL_RSTAT, "sleep status");
         axw(`DSWF_OFF_CTRL, 32'h0, r);
         axw(`DSWF_OFF_WAKE, 32'h0, r);
         axr(`DSWF_OFF_ISTAT, wv, r);
         repeat (12) @(posedge clk);
         pin_chk(1, 1'b0, "irq cleared by read");
         rd_chk(`DSWF_OFF_WAKE, 32'h0, "flags cleared");
      end
      axw(`DSWF_OFF_CTRL, 32'h1, r);
      bor <= 1'b1;
      repeat (20) @(posedge clk);
      pin_chk(0, 1'b1, "brownout does not wake");
      bor <= 1'b0;
      rd_chk(`DSWF_OFF_CTRL, 32'h7, "brownout recorded");
      set_src(2, 1'b1);
      wait_wake();
      set_src(2, 1'b0);
      rd_chk(`DSWF_OFF_ISTAT, 32'h3, "wake and brownout events");
      axw(`DSWF_OFF_CTRL, 32'h0, r);
      axw(`DSWF_OFF_WAKE, 32'h0, r);
      axw(`DSWF_OFF_CTRL, 32'h1, r);
      set_src(0, 1'b1);
      set_src(4, 1'b1);
      // Pins need four edges to reach the flags; same-clock sources join them there
      repeat (4) @(posedge clk);
      for (int i = 1; i < 4; i++) set_src(i, 1'b1);
      wait_wake();
      for (int i = 0; i < 5; i++) set_src(i, 1'b0);
      repeat (12) @(posedge clk);
      cur = `DSWF_WAKE_SLEEP_ONLY;
      rd_chk(`DSWF_OFF_WAKE, {16'h0, cur}, "all sleep flags");
      for (int k = 0; k < 8; k++) begin
         wv = (k == 0) ? 32'hFFFF_FFFF : $urandom;
         axw(`DSWF_OFF_WAKE, wv, r);
         cur = cur & wv[15:0];
         rd_chk(`DSWF_OFF_WAKE, {16'h0, cur}, "random clear");
      end
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      finish_test();
   end
endmodule
`default_nettype wire
